// >>> rtl/dbcl_defs.vh
// Constants for the two-band compressor/limiter: register map, reset values, timing
`ifndef DBCL_DEFS_VH
`define DBCL_DEFS_VH
// Parameter word indices; byte address is four times the index
`define PI_MAIN_TCONST 5'd0
`define PI_MAIN_HOLD   5'd1
`define PI_MAIN_REL    5'd2
`define PI_LOOKAHEAD   5'd3
`define PI_POSTGAIN    5'd4
`define PI_SUB_TCONST  5'd5
`define PI_SUB_HOLD    5'd6
`define PI_SUB_REL     5'd7
`define PI_SUB_LW      5'd8
`define PI_SUB_RW      5'd9
`define PI_BQ_B0       5'd10
`define PI_BQ_B1       5'd11
`define PI_BQ_B2       5'd12
`define PI_BQ_A1       5'd13
`define PI_BQ_A2       5'd14
`define PI_REINJ_L     5'd15
`define PI_REINJ_R     5'd16
`define PRM_COUNT      5'd17
// Read-only status words
`define PI_MAIN_LEVEL  5'd17
`define PI_SUB_LEVEL   5'd18
// Gain table windows (byte address bits 11:8)
`define TAB_MAIN_PAGE  4'h1
`define TAB_SUB_PAGE   4'h2
`define TAB_LEN        6'd33
`define TAB_LAST       6'd32
// Reset values (2.20 fixed point)
`define UNITY_2P20     22'h100000
`define HALF_2P20      22'h080000
// Release unit, in thousandths of a dB per second per count
`define REL_UNIT_MDB   137
// Table step, in thousandths of a dB
`define TAB_STEP_MDB   3000
// AXI responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// >>> rtl/dual_band_compressor_limiter.v
// Two-band compressor/limiter with look-ahead, post gain and sub reinjection
`timescale 1ns/1ps
`default_nettype none
`include "dbcl_defs.vh"
module dual_band_compressor_limiter #(
  parameter       FS_HZ  = 48000,
  parameter [6:0] LA_MAX = 7'd100
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // AXI4-Lite register slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Audio in
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [23:0] in_left,
  input  wire [23:0] in_right,
  // Audio out
  output reg         out_valid,
  output reg  [23:0] out_left,
  output reg  [23:0] out_right,
  output reg  [23:0] out_sub
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_BQ   = 3'd1;
  localparam [2:0] S_SUBD = 3'd2;
  localparam [2:0] S_GAIN = 3'd3;
  localparam [2:0] S_POST = 3'd4;
  localparam [2:0] S_OUT  = 3'd5;

  reg  [21:0] prm [0:16];
  reg  [23:0] dl_l [0:LA_MAX];
  reg  [23:0] dl_r [0:LA_MAX];
  reg         aw_hold_reg, w_hold_reg;
  reg  [11:0] awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  post_cnt_reg;
  reg  [6:0]  wp_reg;
  reg  [23:0] mid_reg, subin_reg, dly_l_reg, dly_r_reg, bq_reg;
  reg  [23:0] bx1_reg, bx2_reg, by1_reg, by2_reg;
  reg  signed [31:0] wk_l_reg, wk_r_reg, wk_s_reg;
  wire [21:0] g_main, g_sub;
  wire [13:0] lv_main, lv_sub;
  integer     k;

  // Saturate a wide signed value to a 24-bit sample
  function [23:0] sat24;
    input signed [63:0] x;
    begin
      if (x > 64'sd8388607)
        sat24 = 24'h7fffff;
      else if (x < -64'sd8388608)
        sat24 = 24'h800000;
      else
        sat24 = x[23:0];
    end
  endfunction

  // Write decode: parameter words and the two table pages
  wire [9:0]  wa       = awaddr_reg[11:2];
  wire        wr_prm   = (awaddr_reg[11:8] == 4'h0) && (wa < {5'd0, `PRM_COUNT});
  wire        wr_tm    = (awaddr_reg[11:8] == `TAB_MAIN_PAGE) && (awaddr_reg[7:2] < `TAB_LEN);
  wire        wr_ts    = (awaddr_reg[11:8] == `TAB_SUB_PAGE) && (awaddr_reg[7:2] < `TAB_LEN);
  wire        wr_go    = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire [31:0] wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] wmerged  = ({10'h000, prm[wa[4:0]]} & ~wmask) | (wdata_reg & wmask);
  wire [21:0] tab_data = wdata_reg[21:0] & wmask[21:0];

  // Write channels taken in either order, one write in flight
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 12'h000;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_prm || wr_tm || wr_ts) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
      end
    end
  end

  // Parameter words; weights and gains start at sensible pass-through values
  always @(posedge ref_clk) begin
    if (!resetn) begin
      for (k = 0; k < 17; k = k + 1)
        prm[k] <= 22'h000000;
      prm[`PI_POSTGAIN] <= `UNITY_2P20;
      prm[`PI_SUB_LW]   <= `HALF_2P20;
      prm[`PI_SUB_RW]   <= `HALF_2P20;
      prm[`PI_BQ_B0]    <= `UNITY_2P20;
    end else if (wr_go && wr_prm) begin
      prm[wa[4:0]] <= wmerged[21:0];
    end
  end

  // Read channel; table pages read as zero, status words show held levels
  wire [9:0] ra     = s_axi_araddr[11:2];
  wire       rd_prm = (s_axi_araddr[11:8] == 4'h0) && (ra < {5'd0, `PRM_COUNT});
  wire       rd_st  = (ra == {5'd0, `PI_MAIN_LEVEL}) || (ra == {5'd0, `PI_SUB_LEVEL});
  wire       rd_tab = ((s_axi_araddr[11:8] == `TAB_MAIN_PAGE) || (s_axi_araddr[11:8] == `TAB_SUB_PAGE))
                      && (s_axi_araddr[7:2] < `TAB_LEN);
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (rd_prm || rd_st || rd_tab) ? `RESP_OKAY : `RESP_SLVERR;
      if (rd_prm)
        s_axi_rdata <= {10'h000, prm[ra[4:0]]};
      else if (ra == {5'd0, `PI_MAIN_LEVEL})
        s_axi_rdata <= {18'h00000, lv_main};
      else if (ra == {5'd0, `PI_SUB_LEVEL})
        s_axi_rdata <= {18'h00000, lv_sub};
      else
        s_axi_rdata <= 32'h00000000;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Look-ahead read pointer; counts above the line length are clamped
  wire [6:0] la = (prm[`PI_LOOKAHEAD] > {15'd0, LA_MAX}) ? LA_MAX : prm[`PI_LOOKAHEAD][6:0];
  wire [6:0] rp = (wp_reg >= la) ? wp_reg - la : wp_reg + LA_MAX + 7'd1 - la;

  // Input products: main detector mid and weighted sub sum
  wire signed [24:0] lr_sum = $signed(in_left) + $signed(in_right);
  wire signed [63:0] sub_w  = ($signed(in_left) * $signed(prm[`PI_SUB_LW]) +
                               $signed(in_right) * $signed(prm[`PI_SUB_RW])) >>> 20;

  // Detector biquad, direct form one
  wire signed [63:0] bq_acc = ($signed(subin_reg) * $signed(prm[`PI_BQ_B0]) +
                               $signed(bx1_reg) * $signed(prm[`PI_BQ_B1]) +
                               $signed(bx2_reg) * $signed(prm[`PI_BQ_B2]) -
                               $signed(by1_reg) * $signed(prm[`PI_BQ_A1]) -
                               $signed(by2_reg) * $signed(prm[`PI_BQ_A2])) >>> 20;
  wire [23:0] bq_y = sat24(bq_acc);

  // Gain and reinjection products
  wire signed [63:0] pg_l = ($signed(wk_l_reg) * $signed({1'b0, prm[`PI_POSTGAIN]})) >>> 20;
  wire signed [63:0] pg_r = ($signed(wk_r_reg) * $signed({1'b0, prm[`PI_POSTGAIN]})) >>> 20;
  wire signed [63:0] pg_s = ($signed(wk_s_reg) * $signed({1'b0, prm[`PI_POSTGAIN]})) >>> 20;
  wire signed [63:0] gm_l = ($signed(dly_l_reg) * $signed({1'b0, g_main})) >>> 20;
  wire signed [63:0] gm_r = ($signed(dly_r_reg) * $signed({1'b0, g_main})) >>> 20;
  wire signed [63:0] gm_s = ($signed(subin_reg) * $signed({1'b0, g_sub})) >>> 20;
  wire signed [63:0] ri_l = $signed(wk_l_reg) + (($signed(wk_s_reg) * $signed(prm[`PI_REINJ_L])) >>> 20);
  wire signed [63:0] ri_r = $signed(wk_r_reg) + (($signed(wk_s_reg) * $signed(prm[`PI_REINJ_R])) >>> 20);

  rms_peak_detector #(.FS_HZ(FS_HZ)) u_main_det (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .en       (state_reg == S_BQ),
    .sample   (mid_reg),
    .tconst   (prm[`PI_MAIN_TCONST]),
    .hold     (prm[`PI_MAIN_HOLD]),
    .rel_rate (prm[`PI_MAIN_REL]),
    .tab_we   (wr_go && wr_tm),
    .tab_idx  (awaddr_reg[7:2]),
    .tab_data (tab_data),
    .gain     (g_main),
    .level    (lv_main)
  );

  rms_peak_detector #(.FS_HZ(FS_HZ)) u_sub_det (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .en       (state_reg == S_SUBD),
    .sample   (bq_reg),
    .tconst   (prm[`PI_SUB_TCONST]),
    .hold     (prm[`PI_SUB_HOLD]),
    .rel_rate (prm[`PI_SUB_REL]),
    .tab_we   (wr_go && wr_ts),
    .tab_idx  (awaddr_reg[7:2]),
    .tab_data (tab_data),
    .gain     (g_sub),
    .level    (lv_sub)
  );

  // Samples are taken only while idle; upstream stalls otherwise
  assign in_ready = (state_reg == S_IDLE);

  // Delay line memory, written once per taken sample
  always @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      dl_l[wp_reg] <= in_left;
      dl_r[wp_reg] <= in_right;
    end
  end

  // Per-sample sequence: capture, biquad, detect, gain, post gain, output
  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg    <= S_IDLE;
      post_cnt_reg <= 3'd0;
      wp_reg       <= 7'd0;
      mid_reg      <= 24'h000000;
      subin_reg    <= 24'h000000;
      dly_l_reg    <= 24'h000000;
      dly_r_reg    <= 24'h000000;
      bq_reg       <= 24'h000000;
      bx1_reg      <= 24'h000000;
      bx2_reg      <= 24'h000000;
      by1_reg      <= 24'h000000;
      by2_reg      <= 24'h000000;
      wk_l_reg     <= 32'sd0;
      wk_r_reg     <= 32'sd0;
      wk_s_reg     <= 32'sd0;
      out_valid    <= 1'b0;
      out_left     <= 24'h000000;
      out_right    <= 24'h000000;
      out_sub      <= 24'h000000;
    end else begin
      out_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (in_valid) begin
            mid_reg   <= lr_sum[24:1];
            subin_reg <= sat24(sub_w);
            dly_l_reg <= (la == 7'd0) ? in_left : dl_l[rp];
            dly_r_reg <= (la == 7'd0) ? in_right : dl_r[rp];
            wp_reg    <= (wp_reg == LA_MAX) ? 7'd0 : wp_reg + 7'd1;
            state_reg <= S_BQ;
          end
        end
        S_BQ: begin
          bq_reg    <= bq_y;
          bx1_reg   <= subin_reg;
          bx2_reg   <= bx1_reg;
          by1_reg   <= bq_y;
          by2_reg   <= by1_reg;
          state_reg <= S_SUBD;
        end
        S_SUBD: begin
          state_reg <= S_GAIN;
        end
        S_GAIN: begin
          wk_l_reg     <= gm_l[31:0];
          wk_r_reg     <= gm_r[31:0];
          wk_s_reg     <= gm_s[31:0];
          post_cnt_reg <= 3'd0;
          state_reg    <= S_POST;
        end
        S_POST: begin
          // 32-bit working words leave room for 48 dB above full scale
          wk_l_reg     <= pg_l[31:0];
          wk_r_reg     <= pg_r[31:0];
          wk_s_reg     <= pg_s[31:0];
          post_cnt_reg <= post_cnt_reg + 3'd1;
          if (post_cnt_reg == 3'd4)
            state_reg <= S_OUT;
        end
        S_OUT: begin
          out_left  <= sat24(ri_l);
          out_right <= sat24(ri_r);
          out_sub   <= sat24({{32{wk_s_reg[31]}}, wk_s_reg});
          out_valid <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/rms_peak_detector.v
// Rms detector with peak hold, release ramp and interpolated gain table
`timescale 1ns/1ps
`default_nettype none
`include "dbcl_defs.vh"
module rms_peak_detector #(
  parameter FS_HZ = 48000
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Sample strobe and data
  input  wire        en,
  input  wire [23:0] sample,
  // Time constants
  input  wire [21:0] tconst,
  input  wire [21:0] hold,
  input  wire [21:0] rel_rate,
  // Gain table load
  input  wire        tab_we,
  input  wire [5:0]  tab_idx,
  input  wire [21:0] tab_data,
  // Results
  output wire [21:0] gain,
  output wire [13:0] level
);
  // Release step per count per sample, in table steps with 32 fraction bits
  localparam [63:0] REL_STEP = (64'd`REL_UNIT_MDB * 64'h100000000) / (64'd`TAB_STEP_MDB * FS_HZ);

  reg  [47:0] ms_reg;
  reg  [37:0] held_reg;
  reg  [21:0] hold_cnt_reg;
  reg  [21:0] tab [0:32];
  integer     i;
  integer     j;

  // Squared input smoothed by one pole, 2.20 coefficient
  wire signed [47:0] sq     = $signed(sample) * $signed(sample);
  wire signed [48:0] diff   = $signed({1'b0, sq}) - $signed({1'b0, ms_reg});
  wire signed [71:0] step   = diff * $signed({1'b0, tconst});
  wire signed [71:0] stepsh = step >>> 20;
  wire        [47:0] ms_next = ms_reg + stepsh[47:0];

  // Log of power: one bit of power is one 3 dB table step of amplitude
  wire [32:0] v = ms_next[46:14];
  reg  [5:0]  p;
  reg  [32:0] vsh;
  always @* begin
    p = 6'd0;
    for (i = 0; i < 33; i = i + 1) begin
      if (v[i])
        p = i[5:0];
    end
    vsh = v << (6'd32 - p);
  end
  wire [37:0] cur = {p, vsh[31:24], 24'h000000};

  // Release decrement, floored at the live rms value
  wire [63:0] dec_w  = rel_rate * REL_STEP;
  wire [37:0] dec    = dec_w[37:0];
  wire        no_dip = (held_reg > dec) && (held_reg - dec > cur);

  // Peak ride, hold, then ramp down
  always @(posedge ref_clk) begin
    if (!resetn) begin
      ms_reg       <= 48'h000000000000;
      held_reg     <= 38'h0000000000;
      hold_cnt_reg <= 22'h000000;
    end else if (en) begin
      ms_reg <= ms_next;
      if (cur > held_reg) begin
        held_reg     <= cur;
        hold_cnt_reg <= hold;
      end else if (hold_cnt_reg != 22'h000000) begin
        hold_cnt_reg <= hold_cnt_reg - 22'h000001;
      end else begin
        held_reg <= no_dip ? held_reg - dec : cur;
      end
    end
  end

  // Gain table, unity after reset so an unloaded table passes audio
  always @(posedge ref_clk) begin
    if (!resetn) begin
      // Own loop index so the combinational search keeps a single driver
      for (j = 0; j < 33; j = j + 1)
        tab[j] <= `UNITY_2P20;
    end else if (tab_we && tab_idx < `TAB_LEN) begin
      tab[tab_idx] <= tab_data;
    end
  end

  // Upper bits select, lower bits interpolate
  wire [5:0]  idx0 = held_reg[37:32];
  wire [5:0]  idx1 = (idx0 >= `TAB_LAST) ? `TAB_LAST : idx0 + 6'd1;
  wire signed [22:0] tdiff = $signed({1'b0, tab[idx1]}) - $signed({1'b0, tab[idx0]});
  wire signed [31:0] tint  = (tdiff * $signed({1'b0, held_reg[31:24]})) >>> 8;
  wire signed [31:0] gsum  = $signed({10'h000, tab[idx0]}) + tint;
  assign gain  = gsum[21:0];
  assign level = held_reg[37:24];
endmodule
`default_nettype wire

// >>> tb/audio_stream_partner.sv
// Audio source and result sink standing in for the input path and output stages
`timescale 1ns/1ps
`default_nettype none
module audio_stream_partner (
  // Clock
  input  wire logic        ref_clk,
  // Sample source
  output var  logic        in_valid,
  input  wire logic        in_ready,
  output var  logic [23:0] in_left,
  output var  logic [23:0] in_right,
  // Result sink
  input  wire logic        out_valid,
  input  wire logic [23:0] out_left,
  input  wire logic [23:0] out_right,
  input  wire logic [23:0] out_sub
);
  logic [71:0] q[$];
  // Idle source at time zero
  initial begin
    in_valid = 1'b0;
    in_left  = 24'h000000;
    in_right = 24'h000000;
  end
  // Hold the sample until taken; idle lines get the inverse so stale data never looks valid
  task automatic send(input logic [23:0] l, r, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_left  <= l;
    in_right <= r;
    do @(posedge ref_clk); while (!in_ready);
    in_valid <= 1'b0;
    in_left  <= ~l;
    in_right <= ~r;
  endtask
  // Capture on the strobe only, the data stand until the next one
  always @(posedge ref_clk) begin
    if (out_valid) q.push_back({out_left, out_right, out_sub});
  end
endmodule
`default_nettype wire

// >>> tb/dbcl_sva.sv
// Port-level assertions for the two-band compressor/limiter
`timescale 1ns/1ps
`default_nettype none
module dbcl_sva (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Audio
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic [23:0] out_left,
  input wire logic [23:0] out_right,
  input wire logic [23:0] out_sub
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Sample taken, then nine busy cycles before the single result strobe
  sequence take_s;
    in_valid && in_ready;
  endsequence
  sequence result_s;
    (!out_valid)[*8] ##1 !out_valid ##1 out_valid;
  endsequence
  sequence busy_s;
    (!in_ready)[*8] ##1 !in_ready ##1 in_ready;
  endsequence
  chk_out_latency: assert property (take_s |=> result_s)
    else $error("result strobe not ten cycles after take");
  chk_busy_span: assert property (take_s |=> busy_s)
    else $error("input ready wrong while sample in flight");
  chk_pulse_one: assert property (out_valid |=> !out_valid)
    else $error("result strobe longer than one cycle");
  // Results stand between strobes so a slow sink still reads them whole
  chk_out_stable: assert property (!out_valid |-> $stable({out_left, out_right, out_sub}))
    else $error("output sample changed without strobe");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                  |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_wr_reopen: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write channel not reopened after response");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_rd_reopen: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened after data");
endmodule
bind dual_band_compressor_limiter dbcl_sva u_sva (.ref_clk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .in_valid, .in_ready, .out_valid, .out_left, .out_right, .out_sub);
`default_nettype wire

// >>> tb/dual_band_compressor_limiter_tb.sv
// Self-checking bench for the two-band compressor/limiter
`timescale 1ns/1ps
`default_nettype none
`include "dbcl_defs.vh"
module dual_band_compressor_limiter_tb;
  logic             ref_clk = 1'b0;
  logic             resetn = 1'b0;
  logic [11:0]      s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]      s_axi_wdata = 32'h0, rdat;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0]       resp;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic        in_valid, in_ready, out_valid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [23:0] in_left, in_right, out_left, out_right, out_sub;
  int               failures = 0, checks_done = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  dual_band_compressor_limiter DUT (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .in_valid, .in_ready, .in_left, .in_right, .out_valid, .out_left, .out_right, .out_sub);
  audio_stream_partner p (.ref_clk, .in_valid, .in_ready, .in_left, .in_right, .out_valid, .out_left,
    .out_right, .out_sub);

  // Comparison and verdict
  task automatic check(input logic [31:0] got, exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [11:0] adr(input logic [4:0] i);
    return {5'h00, i, 2'b00};
  endfunction
  // Bus master: both write channels offered together, ready held until the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    check(rdat, exp, "register read");
    check(resp, `RESP_OKAY, "read response");
  endtask
  task automatic chk_out(input logic [23:0] l, r, s);
    logic [71:0] o;
    wait (p.q.size() != 0);
    o = p.q.pop_front();
    check(o[71:48], l, "left out");
    check(o[47:24], r, "right out");
    check(o[23:0], s, "sub out");
  endtask

  // Scenarios
  task automatic t_reset;
    rd_chk(adr(`PI_POSTGAIN), `UNITY_2P20);
    rd_chk(adr(`PI_SUB_LW), `HALF_2P20);
    rd_chk(adr(`PI_SUB_RW), `HALF_2P20);
    rd_chk(adr(`PI_BQ_B0), `UNITY_2P20);
    rd_chk(adr(`PI_REINJ_L), 32'h0);
    rd(12'hffc);
    check(resp, `RESP_SLVERR, "unmapped read");
    wr(adr(`PI_MAIN_LEVEL), 32'h1);
    check(resp, `RESP_SLVERR, "status write");
    $display("test reset_values done");
  endtask
  task automatic t_path;
    p.send(24'h000400, 24'h000800, 0);
    p.send(24'hfffc00, 24'h000400, 0);
    chk_out(24'h000400, 24'h000800, 24'h000600);
    chk_out(24'hfffc00, 24'h000400, 24'h000000);
    $display("test unity_path done");
  endtask
  task automatic t_post;
    wr(adr(`PI_POSTGAIN), 32'h180000);
    p.send(24'h000400, 24'h000400, 3);
    chk_out(24'h001e60, 24'h001e60, 24'h001e60);
    wr(adr(`PI_POSTGAIN), `UNITY_2P20);
    $display("test post_gain done");
  endtask
  task automatic t_look;
    logic [71:0] o;
    wr(adr(`PI_LOOKAHEAD), 32'hc8);
    rd_chk(adr(`PI_LOOKAHEAD), 32'hc8);
    wr(adr(`PI_LOOKAHEAD), 32'h3);
    for (int i = 0; i < 6; i++) p.send(24'((i + 1) * 256), 24'((i + 1) * 256), 0);
    for (int i = 0; i < 6; i++) begin
      wait (p.q.size() != 0);
      o = p.q.pop_front();
      if (i >= 3) check(o[71:48], 24'((i - 2) * 256), "delayed left");
      if (i >= 3) check(o[47:24], 24'((i - 2) * 256), "delayed right");
      check(o[23:0], 24'((i + 1) * 256), "sub undelayed");
    end
    wr(adr(`PI_LOOKAHEAD), 32'h0);
    $display("test lookahead done");
  endtask
  task automatic t_reinj;
    wr(adr(`PI_SUB_RW), 32'h0);
    wr(adr(`PI_SUB_LW), `UNITY_2P20);
    wr(adr(`PI_REINJ_L), `UNITY_2P20);
    p.send(24'h000400, 24'h000bb8, 0);
    chk_out(24'h000800, 24'h000bb8, 24'h000400);
    wr(adr(`PI_SUB_LW), `HALF_2P20);
    wr(adr(`PI_SUB_RW), `HALF_2P20);
    wr(adr(`PI_REINJ_L), 32'h0);
    $display("test reinjection done");
  endtask
  task automatic t_table;
    for (int i = 0; i < 33; i++) wr(12'(12'h100 + i * 4), `HALF_2P20);
    p.send(24'h000400, 24'h000400, 0);
    chk_out(24'h000200, 24'h000200, 24'h000400);
    $display("test gain_table done");
  endtask
  // Detector biquad nulled: sub audio still passes, sub detector stays at zero
  task automatic t_sub;
    for (int i = 0; i < 33; i++) wr(12'(12'h200 + i * 4), `HALF_2P20);
    wr(adr(`PI_SUB_TCONST), `UNITY_2P20);
    wr(adr(`PI_BQ_B0), 32'h0);
    p.send(24'h400000, 24'h400000, 0);
    chk_out(24'h200000, 24'h200000, 24'h200000);
    rd_chk(adr(`PI_SUB_LEVEL), 32'h0);
    wr(adr(`PI_BQ_B0), `UNITY_2P20);
    $display("test sub_detector done");
  endtask
  task automatic t_level;
    logic [31:0] la, lb;
    wr(adr(`PI_MAIN_TCONST), `UNITY_2P20);
    wr(adr(`PI_MAIN_HOLD), 32'h4);
    wr(adr(`PI_MAIN_REL), 32'h3fffff);
    p.send(24'h040000, 24'h040000, 0);
    rd(adr(`PI_MAIN_LEVEL));
    la = rdat;
    check(32'(la != 32'h0), 32'h1, "level rises");
    p.send(24'h400000, 24'h400000, 0);
    rd(adr(`PI_MAIN_LEVEL));
    lb = rdat;
    check(32'(lb > la), 32'h1, "louder replaces held");
    repeat (2) p.send(24'h000000, 24'h000000, 0);
    rd_chk(adr(`PI_MAIN_LEVEL), lb);
    repeat (8) p.send(24'h000000, 24'h000000, 0);
    rd(adr(`PI_MAIN_LEVEL));
    check(32'(rdat < lb), 32'h1, "release ramps down");
    p.q.delete();
    $display("test hold_release done");
  endtask

  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset;
    t_path;
    t_post;
    t_look;
    t_reinj;
    t_table;
    t_sub;
    t_level;
    final_report;
  end
  // Watchdog well beyond the under one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
endmodule
`default_nettype wire
